// *** scr_pkg.sv ***
// Purpose: Shared constants and carriers for the clock ratio select block
// Assumes: One 25 MHz system clock, Avalon-MM register access
// Notes: Register offsets are byte addresses of 32-bit words
package scr_pkg;
    // Register byte offsets
    localparam logic [3:0] SCR_OFS_CTRL = 4'h0;
    localparam logic [3:0] SCR_OFS_STRAP = 4'h4;
    localparam logic [3:0] SCR_OFS_RATIO = 4'h8;
    localparam logic [3:0] SCR_OFS_ID = 4'hc;
    // Control register fields
    localparam int SCR_CTRL_SYNC_DIV_BIT = 0;
    localparam int SCR_CTRL_OUT_DIV_LSB = 8;
    localparam int SCR_CTRL_VCO_LSB = 16;
    // Strap word layout
    localparam int SCR_STRAP_MULT_LSB = 0;
    localparam int SCR_STRAP_CORE_LSB = 4;
    localparam int SCR_STRAP_DIV_BIT = 11;
    localparam int SCR_STRAP_AGENT_BIT = 12;
    localparam int SCR_STRAP_W = 13;
    // Reset values
    localparam logic [31:0] SCR_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SCR_ID_VALUE = 32'h5c12_0001; // Arbitrary value
    // Lock detection window of sync edges
    localparam int SCR_LOCK_EDGES = 8;
    localparam logic [6:0] SCR_CORE_VALID_MASK_LO = 7'h00;

    typedef enum logic [1:0] {
        SCR_ST_RESET,
        SCR_ST_CAPTURE,
        SCR_ST_RUN
    } scr_state_t;

    typedef struct packed {
        logic agent_mode;
        logic ref_divide_strap;
        logic [6:0] core_ratio_field;
        logic [3:0] system_pll_mult_field;
    } scr_strap_t;

    typedef struct packed {
        logic supported;
        logic [4:0] bus_ratio;
        logic core_valid;
    } scr_ratio_t;
endpackage

// *** scr_ratio_dec.sv ***
// Purpose: Decode reset-latched straps into the system bus ratio
// Assumes: Straps are stable once captured
// Notes: Pure combinational lookup
`timescale 1ns/1ps
module scr_ratio_dec (
    // Straps in
    input wire scr_pkg::scr_strap_t strap,
    // Decoded ratio out
    output scr_pkg::scr_ratio_t ratio
);
    import scr_pkg::*;
    logic [4:0] field_val;

    always_comb begin
        field_val = (strap.system_pll_mult_field == 4'h0) ? 5'h10 :
                    {1'b0, strap.system_pll_mult_field};
        ratio.bus_ratio = 5'h00;
        ratio.supported = 1'b0;
        // Zero is the one core code treated as reserved here
        ratio.core_valid = (strap.core_ratio_field != 7'h00);
        if (!strap.agent_mode) begin
            if (!strap.ref_divide_strap) begin
                if (field_val >= 5'h06) begin
                    ratio.bus_ratio = field_val;
                    ratio.supported = 1'b1;
                end
            end else if (field_val >= 5'h02 && field_val <= 5'h08) begin
                ratio.bus_ratio = field_val;
                ratio.supported = 1'b1;
            end
        end else begin
            if (!strap.ref_divide_strap) begin
                if (field_val >= 5'h02) begin
                    ratio.bus_ratio = field_val;
                    ratio.supported = 1'b1;
                end
            end else if (field_val >= 5'h02 && field_val <= 5'h08) begin
                ratio.bus_ratio = {field_val[3:0], 1'b0};
                ratio.supported = 1'b1;
            end
        end
        if (!ratio.supported) begin
            ratio.bus_ratio = 5'h00;
        end
    end
endmodule

// *** scr_clock_select.sv ***
// Purpose: Clock source and ratio selection with strap capture
// Assumes: Reference clocks arrive as pins sampled at 25 MHz
// Notes: Output clocks are sampled-domain levels, not true clocks
//        Straps relatch only at the next power-on release
`timescale 1ns/1ps
module scr_clock_select #(
    parameter int N_OUT = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Reset pins from board
    input wire logic power_on_reset_n,
    input wire logic hard_reset_n,
    // Strap and clock pins
    input wire logic [scr_pkg::SCR_STRAP_W-1:0] strap_in,
    output logic [scr_pkg::SCR_STRAP_W-1:0] strap_out,
    output logic [scr_pkg::SCR_STRAP_W-1:0] strap_oe,
    input wire logic primary_ref_clock_in,
    input wire logic bus_clk_in,
    input wire logic bus_sync_in,
    output logic bus_sync_out,
    output logic [N_OUT-1:0] bus_clk_out,
    // Status
    output logic sync_locked,
    output logic config_supported,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import scr_pkg::*;

    // Select bits must fit below the pin output field
    if (N_OUT < 1 || N_OUT > 8) begin : g_bad_n_out
        $error("N_OUT must be 1 to 8");
    end

    // Three-stage samplers for pins
    logic [2:0] por_sr, hrst_sr, ref_sr, bclk_sr, sync_sr;
    logic [SCR_STRAP_W-1:0] strap_s1, strap_s2, strap_s3;
    logic por_q, hrst_q, ref_q, bclk_q, sync_q;
    logic [SCR_STRAP_W-1:0] strap_q;
    // Strap receivers listen only while the pins are inputs
    logic pins_input;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            por_sr <= 3'h0;
            hrst_sr <= 3'h0;
            ref_sr <= 3'h0;
            bclk_sr <= 3'h0;
            sync_sr <= 3'h0;
        end else begin
            por_sr <= {por_sr[1:0], power_on_reset_n};
            hrst_sr <= {hrst_sr[1:0], hard_reset_n};
            ref_sr <= {ref_sr[1:0], primary_ref_clock_in};
            bclk_sr <= {bclk_sr[1:0], bus_clk_in};
            sync_sr <= {sync_sr[1:0], bus_sync_in};
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            strap_s1 <= '0;
            strap_s2 <= '0;
            strap_s3 <= '0;
        end else if (pins_input) begin
            strap_s1 <= strap_in;
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
        end
    end

    // Filtered levels: change only once stages two and three agree
    always_ff @(posedge clk) begin
        if (!nrst) begin
            por_q <= 1'b0;
            hrst_q <= 1'b0;
            ref_q <= 1'b0;
            bclk_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            if (por_sr[1] == por_sr[2]) por_q <= por_sr[2];
            if (hrst_sr[1] == hrst_sr[2]) hrst_q <= hrst_sr[2];
            if (ref_sr[1] == ref_sr[2]) ref_q <= ref_sr[2];
            if (bclk_sr[1] == bclk_sr[2]) bclk_q <= bclk_sr[2];
            if (sync_sr[1] == sync_sr[2]) sync_q <= sync_sr[2];
        end
    end

    // Per-bit strap filter, same agreement rule as the pins
    genvar si;
    generate
        for (si = 0; si < SCR_STRAP_W; si++) begin : g_strap
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    strap_q[si] <= 1'b0;
                end else if (strap_s2[si] == strap_s3[si]) begin
                    strap_q[si] <= strap_s3[si];
                end
            end
        end
    endgenerate

    // Strap capture sequence
    scr_state_t state;
    scr_strap_t straps;
    logic por_q_d;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            por_q_d <= 1'b0;
        end else begin
            por_q_d <= por_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= SCR_ST_RESET;
        end else if (!por_q) begin
            // Any power-on drop restarts the capture
            state <= SCR_ST_RESET;
        end else begin
            case (state)
                SCR_ST_RESET: state <= SCR_ST_CAPTURE;
                SCR_ST_CAPTURE: state <= SCR_ST_RUN;
                SCR_ST_RUN: state <= SCR_ST_RUN;
                default: state <= SCR_ST_RESET;
            endcase
        end
    end

    // Latch on power-on release, held until the next power-on release
    always_ff @(posedge clk) begin
        if (!nrst) begin
            straps <= '0;
        end else if (por_q && !por_q_d) begin
            straps.system_pll_mult_field <= strap_q[SCR_STRAP_MULT_LSB +: 4];
            straps.core_ratio_field <=
                strap_q[SCR_STRAP_CORE_LSB +: 7];
            straps.ref_divide_strap <= strap_q[SCR_STRAP_DIV_BIT];
            straps.agent_mode <= strap_q[SCR_STRAP_AGENT_BIT];
        end
    end

    // Pins float as inputs during hard reset or before capture
    assign pins_input = !hrst_q || (state != SCR_ST_RUN);

    logic [31:0] ctrl;
    logic [31:0] ctrl_wmask;

    // Unused control bits read back as zero
    always_comb begin
        ctrl_wmask = 32'h0000_0000;
        ctrl_wmask[SCR_CTRL_OUT_DIV_LSB +: N_OUT] = {N_OUT{1'b1}};
        ctrl_wmask[SCR_CTRL_VCO_LSB +: SCR_STRAP_W] = {SCR_STRAP_W{1'b1}};
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            strap_oe <= '0;
            strap_out <= '0;
        end else begin
            // Pins drive the control word only after capture
            strap_oe <= pins_input ? '0 : {SCR_STRAP_W{1'b1}};
            strap_out <= ctrl[SCR_STRAP_W+16-1:16];
        end
    end

    // Ratio decode
    scr_ratio_t ratio;
    scr_ratio_dec u_dec (
        .strap(straps),
        .ratio(ratio)
    );

    // Primary clock edge pick
    // Halver steps only in host mode; agent takes the bus clock
    logic prim_q, prim_d, prim_rise, half_q;
    always_comb begin
        prim_q = straps.agent_mode ? bclk_q : ref_q;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            prim_d <= 1'b0;
            half_q <= 1'b0;
        end else begin
            prim_d <= prim_q;
            if (prim_rise && !straps.agent_mode) begin
                half_q <= ~half_q;
            end
        end
    end
    assign prim_rise = prim_q && !prim_d;

    // Clock outputs only meaningful in host mode
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bus_sync_out <= 1'b0;
        end else if (straps.agent_mode) begin
            bus_sync_out <= 1'b0;
        end else begin
            bus_sync_out <= straps.ref_divide_strap ? half_q : prim_q;
        end
    end

    // One select bit per bus clock output
    genvar gi;
    generate
        for (gi = 0; gi < N_OUT; gi++) begin : g_out
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    bus_clk_out[gi] <= 1'b0;
                end else if (straps.agent_mode) begin
                    bus_clk_out[gi] <= 1'b0;
                end else begin
                    bus_clk_out[gi] <= ctrl[SCR_CTRL_OUT_DIV_LSB + gi] ?
                                       half_q : prim_q;
                end
            end
        end
    endgenerate

    // Lock once the looped-back sync edges arrive steadily
    logic sync_d;
    logic [3:0] sync_cnt;
    logic [7:0] gap_cnt;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sync_d <= 1'b0;
            sync_cnt <= 4'h0;
            gap_cnt <= 8'h00;
            sync_locked <= 1'b0;
        end else if (state != SCR_ST_RUN || straps.agent_mode) begin
            sync_d <= sync_q;
            sync_cnt <= 4'h0;
            gap_cnt <= 8'h00;
            sync_locked <= 1'b0;
        end else begin
            sync_d <= sync_q;
            if (sync_q && !sync_d) begin
                gap_cnt <= 8'h00;
                // Count saturates so lock holds while edges keep coming
                if (sync_cnt != 4'(SCR_LOCK_EDGES)) begin
                    sync_cnt <= sync_cnt + 4'h1;
                end
            end else if (gap_cnt == 8'hff) begin
                // A missing loop-back drops lock
                sync_cnt <= 4'h0;
            end else begin
                gap_cnt <= gap_cnt + 8'h01;
            end
            sync_locked <= (sync_cnt == 4'(SCR_LOCK_EDGES));
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            config_supported <= 1'b0;
        end else begin
            // Reserved core codes and blank cells both clear it
            config_supported <= (state == SCR_ST_RUN) && ratio.supported
                                && ratio.core_valid;
        end
    end

    // Status byte at the ratio offset
    logic [7:0] status;
    always_comb begin
        status = {ratio.supported, ratio.core_valid, sync_locked,
                  ratio.bus_ratio};
    end

    // Register slave: one wait cycle on every access
    logic ack;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end
    // Kept as its own flop so the port leaves a register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !ack);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl <= SCR_CTRL_RST;
        end else if (avs_write && ack && avs_address == SCR_OFS_CTRL) begin
            // Lands on the edge where waitrequest is seen low
            for (int b = 0; b < 4; b++) begin
                if (avs_byteenable[b]) begin
                    ctrl[b*8 +: 8] <= avs_writedata[b*8 +: 8]
                                      & ctrl_wmask[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack) begin
            // Loads in the wait cycle, stands until the next read
            case (avs_address)
                SCR_OFS_CTRL: avs_readdata <= ctrl;
                SCR_OFS_STRAP: avs_readdata <= {19'h0, straps};
                SCR_OFS_RATIO: avs_readdata <= {24'h0, status};
                SCR_OFS_ID: avs_readdata <= SCR_ID_VALUE;
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// *** scr_asserts.sv ***
// Purpose: Port checks for the clock ratio select block
// Assumes: One clock domain, sync active-low reset
// Notes: Lock drop checked with a sync edge age counter
`timescale 1ns/1ps
module scr_asserts import scr_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Pins
    input wire logic power_on_reset_n,
    input wire logic hard_reset_n,
    input wire logic [SCR_STRAP_W-1:0] strap_oe,
    input wire logic bus_sync_in,
    input wire logic sync_locked,
    input wire logic config_supported,
    // Avalon-MM
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [8:0] age;
    logic sync_q;
    // Saturates so a dead loop never wraps back
    always_ff @(posedge clk) begin
        sync_q <= bus_sync_in;
        if (!nrst || (bus_sync_in && !sync_q))
            age <= 9'h000;
        else if (age != 9'h1ff)
            age <= age + 9'h001;
    end
    property p_wait_one;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("no answer");
    property p_idle_wait;
        !(avs_read || avs_write) |-> avs_waitrequest;
    endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("idle ready");
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
            |-> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped data");
    property p_id;
        avs_read && !avs_waitrequest && avs_address == SCR_OFS_ID
            |-> avs_readdata == SCR_ID_VALUE;
    endproperty
    a_id: assert property (p_id) else $error("id value");
    property p_rd_stands;
        !avs_read |=> $stable(avs_readdata);
    endproperty
    a_rd_stands: assert property (p_rd_stands) else $error("data moved");
    property p_oe_hard;
        !hard_reset_n [*8] |-> strap_oe == '0;
    endproperty
    a_oe_hard: assert property (p_oe_hard) else $error("oe in reset");
    property p_sup_stable;
        power_on_reset_n [*2] ##0 strap_oe[0] |=> $stable(config_supported);
    endproperty
    a_sup_stable: assert property (p_sup_stable) else $error("cfg moved");
    property p_lock_drop;
        age == 9'h12c |-> !sync_locked;
    endproperty
    a_lock_drop: assert property (p_lock_drop) else $error("stale lock");
endmodule
bind scr_clock_select scr_asserts u_chk (.clk(clk), .nrst(nrst),
    .power_on_reset_n(power_on_reset_n), .hard_reset_n(hard_reset_n),
    .strap_oe(strap_oe), .bus_sync_in(bus_sync_in),
    .sync_locked(sync_locked), .config_supported(config_supported),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

// *** scr_board.sv ***
// Purpose: Board straps and external clock loop
// Assumes: Strap pins carry 4.7k pull resistors
// Notes: Clocks are slow counters of the sample clock
`timescale 1ns/1ps
module scr_board import scr_pkg::*; (
    // Clock
    input wire logic clk,
    // Resistor levels
    input wire logic [SCR_STRAP_W-1:0] pull,
    // Device pins
    input wire logic [SCR_STRAP_W-1:0] strap_out,
    input wire logic [SCR_STRAP_W-1:0] strap_oe,
    output logic [SCR_STRAP_W-1:0] strap_in,
    input wire logic bus_sync_out,
    output logic bus_sync_in,
    output logic ref_clk,
    output logic bus_clk
);
    logic [3:0] cnt = 4'h0;
    // Undriven pin falls back to its resistor
    assign strap_in = (strap_oe & strap_out) | (~strap_oe & pull);
    assign bus_sync_in = bus_sync_out;
    assign ref_clk = cnt[3];
    always_ff @(posedge clk) begin
        cnt <= cnt + 4'h1;
    end
    // High for six of every sixteen cycles, off the reference phase
    assign bus_clk = (cnt >= 4'h6) && (cnt <= 4'hb);
endmodule

// *** system_clock_ratio_select_tb_top.sv ***
// Purpose: Self-checking bench for the clock ratio select block
// Assumes: Board model supplies straps and clocks
// Notes: Each strap set is latched through a full power-on cycle
`timescale 1ns/1ps
module system_clock_ratio_select_tb_top;
    import scr_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic power_on_reset_n = 1'b0;
    logic hard_reset_n = 1'b0;
    logic [12:0] pull = '0;
    logic [12:0] strap_in, strap_out, strap_oe;
    logic ref_clk, bus_clk, sync_out, locked, supported;
    logic [2:0] clk_out;
    logic [3:0] address = 4'h0;
    logic [3:0] be = 4'hf;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic waitreq;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    logic [5:0] cfgs [9] = '{6'h06, 6'h00, 6'h05, 6'h12, 6'h18,
        6'h22, 6'h2f, 6'h38, 6'h39};
    always #20 clk = ~clk;
    scr_clock_select uut (.clk(clk), .nrst(nrst),
        .power_on_reset_n(power_on_reset_n), .hard_reset_n(hard_reset_n),
        .strap_in(strap_in), .strap_out(strap_out), .strap_oe(strap_oe),
        .primary_ref_clock_in(ref_clk), .bus_clk_in(bus_clk),
        .bus_sync_in(sync_out), .bus_sync_out(sync_out),
        .bus_clk_out(clk_out), .sync_locked(locked),
        .config_supported(supported), .avs_address(address),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
        .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(waitreq));
    scr_board brd (.clk(clk), .pull(pull), .strap_out(strap_out),
        .strap_oe(strap_oe), .strap_in(strap_in), .bus_sync_out(sync_out),
        .bus_sync_in(), .ref_clk(ref_clk), .bus_clk(bus_clk));
    task automatic results();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d, input logic [3:0] b, output logic [31:0] q);
        @(posedge clk);
        address <= a;
        wdata <= d;
        be <= b;
        rd <= !w;
        wr <= w;
        do @(posedge clk); while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Pins change after capture to prove the latch point
    task automatic boot(input logic [12:0] s);
        power_on_reset_n <= 1'b0;
        hard_reset_n <= 1'b0;
        pull <= s;
        repeat (12) @(posedge clk);
        power_on_reset_n <= 1'b1;
        repeat (12) @(posedge clk);
        pull <= ~s;
        check({19'h0, strap_oe}, 32'h0);
        hard_reset_n <= 1'b1;
        repeat (20) @(posedge clk);
        check({19'h0, strap_oe}, 32'h1fff);
    endtask
    task automatic count(output int ns, output int n0, output int n1);
        logic [2:0] p;
        logic [2:0] v;
        ns = 0;
        n0 = 0;
        n1 = 0;
        @(posedge ref_clk);
        @(posedge clk);
        p = {sync_out, clk_out[1:0]};
        repeat (160) begin
            @(posedge clk);
            v = {sync_out, clk_out[1:0]};
            ns += int'(v[2] & ~p[2]);
            n1 += int'(v[1] & ~p[1]);
            n0 += int'(v[0] & ~p[0]);
            p = v;
        end
    endtask
    function automatic logic [4:0] exp_ratio(input logic [5:0] c);
        int r;
        r = (c[3:0] == 4'h0) ? 16 : int'(c[3:0]);
        if (!c[4])
            return (r >= (c[5] ? 2 : 6)) ? 5'(r) : 5'h0;
        if (c[3:0] < 4'h2 || c[3:0] > 4'h8)
            return 5'h0;
        return c[5] ? 5'(2 * r) : 5'(r);
    endfunction
    task automatic run_cfg(input logic [5:0] c);
        logic [12:0] s;
        logic [31:0] q;
        logic [4:0] e;
        int ns, n0, n1;
        s = {c[5], c[4], 7'h05, c[3:0]};
        e = exp_ratio(c);
        boot(s);
        bus(1'b0, SCR_OFS_STRAP, '0, 4'hf, q);
        check(q, {19'h0, s});
        bus(1'b0, SCR_OFS_RATIO, '0, 4'hf, q);
        check({q[7], q[4:0]}, {e != 5'h0, e});
        check({31'h0, supported}, {31'h0, e != 5'h0});
        count(ns, n0, n1);
        check(ns, c[5] ? 0 : (c[4] ? 5 : 10));
        check(n1, c[5] ? 0 : 10);
        // Half-rate loop needs about 260 cycles for eight edges
        repeat (128) @(posedge clk);
        check({31'h0, locked}, {31'h0, !c[5]});
    endtask
    task automatic out_clocks();
        logic [31:0] q;
        int ns, n0, n1;
        boot(13'h0056);
        bus(1'b1, SCR_OFS_CTRL, 32'h1abc_0100, 4'hf, q);
        repeat (2) @(posedge clk);
        check({19'h0, strap_out}, 32'h1abc);
        count(ns, n0, n1);
        check(n0, 5);
        check(n1, 10);
    endtask
    task automatic reg_access();
        logic [31:0] q;
        bus(1'b1, SCR_OFS_CTRL, 32'hffff_ffff, 4'b0010, q);
        bus(1'b0, SCR_OFS_CTRL, '0, 4'hf, q);
        check(q & 32'h1fff_0701, 32'h1abc_0700);
        bus(1'b1, SCR_OFS_STRAP, '0, 4'hf, q);
        bus(1'b0, SCR_OFS_STRAP, '0, 4'hf, q);
        check(q, 32'h0000_0056);
        bus(1'b0, 4'h6, '0, 4'hf, q);
        check(q, 32'h0);
        bus(1'b0, SCR_OFS_ID, '0, 4'hf, q);
        check(q, SCR_ID_VALUE);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 9; i++)
            run_cfg(cfgs[i]);
        out_clocks();
        reg_access();
        results();
    end
endmodule
